// [hdl/key_menu_pkg.sv]
// Shared constants and types for the local key and menu control block
package key_menu_pkg;

  localparam int unsigned CLK_HZ = 50_000_000;
  // Key debounce and combination window, in microseconds
  localparam int unsigned DEBOUNCE_US = 10_000;
  localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1_000_000) * DEBOUNCE_US;
  localparam int unsigned COMBO_US = 60_000;
  localparam int unsigned COMBO_CYC = (CLK_HZ / 1_000_000) * COMBO_US;
  // Initialization time, in milliseconds
  localparam int unsigned INIT_MS = 3_000;
  localparam int unsigned INIT_CYC = (CLK_HZ / 1_000) * INIT_MS;
  // Menu inactivity return time, in seconds
  localparam int unsigned IDLE_S = 180;
  localparam longint unsigned IDLE_CYC = longint'(CLK_HZ) * IDLE_S;
  // Blink period, in milliseconds, and quarter-step ratios
  localparam int unsigned BLINK_MS = 1_000;
  localparam int unsigned BLINK_CYC = (CLK_HZ / 1_000) * BLINK_MS;
  localparam int unsigned SHORT_QUARTERS = 1;
  localparam int unsigned HALF_QUARTERS = 2;
  localparam int unsigned LONG_QUARTERS = 3;

  localparam logic [3:0] MENU_FIRST = 4'h1;
  localparam logic [3:0] MENU_LAST = 4'hA;
  localparam logic [3:0] MENU_LIMITS = 4'h5;
  localparam logic [3:0] READOUT_LAST = 4'hD;
  localparam logic [3:0] DIAG_WRITE_PROT = 4'h1;
  localparam logic [1:0] LANG_LAST = 2'h2;

  typedef enum logic [2:0] {
    LED_OFF,
    LED_ON,
    LED_SHORT,
    LED_LONG,
    LED_EQUAL
  } led_mode_t;

  typedef struct packed {
    logic menu;
    logic up;
    logic down;
    logic confirm;
    logic reset;
  } key_cmd_t;

  typedef struct packed {
    logic menu_key;
    logic up_key;
    logic down_key;
  } keys_t;

  typedef struct packed {
    logic has_lcd;
    logic limits_local_ok;
    logic autostart_done;
    logic write_protect;
    logic diag_message;
    logic diag_error;
  } status_in_t;

endpackage

// [hdl/key_decoder.sv]
// Key debouncer and combination decoder
module key_decoder #(
  parameter int unsigned DEBOUNCE_CYCLES = key_menu_pkg::DEBOUNCE_CYC,
  parameter int unsigned COMBO_CYCLES = key_menu_pkg::COMBO_CYC
)
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire key_menu_pkg::keys_t keys_i,
  output key_menu_pkg::key_cmd_t cmd_o
);

  logic [2:0] raw;
  logic [2:0] stable_q, stable_d;
  logic [2:0] held_q, held_d;
  logic [2:0] seen_q, seen_d;
  logic [19:0] deb_q [3];
  logic [19:0] deb_d [3];
  logic [21:0] win_q, win_d;
  logic collect_q, collect_d;
  key_menu_pkg::key_cmd_t cmd_q, cmd_d;

  assign raw = {keys_i.menu_key, keys_i.up_key, keys_i.down_key};

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_deb
      always_comb
      begin
        deb_d[g] = deb_q[g];
        stable_d[g] = stable_q[g];
        if (raw[g] == stable_q[g])
          deb_d[g] = '0;
        else if (deb_q[g] == 20'(DEBOUNCE_CYCLES - 1))
        begin
          deb_d[g] = '0;
          stable_d[g] = raw[g]; // R23
        end
        else
          deb_d[g] = deb_q[g] + 20'h00001;
      end
      always_ff @(posedge clock_i)
      begin
        if (sys_rst_i)
        begin
          deb_q[g] <= '0;
          stable_q[g] <= 1'b0;
        end
        else
        begin
          deb_q[g] <= deb_d[g];
          stable_q[g] <= stable_d[g];
        end
      end
    end
  endgenerate

  // Gather keys pressed within the window, then emit at most one command
  always_comb
  begin
    held_d = stable_q;
    seen_d = seen_q;
    win_d = win_q;
    collect_d = collect_q;
    cmd_d = '0;
    if (!collect_q)
    begin
      if ((stable_q & ~held_q) != 3'h0)
      begin
        collect_d = 1'b1;
        seen_d = stable_q;
        win_d = '0;
      end
    end
    else
    begin
      seen_d = seen_q | stable_q;
      if (win_q == 22'(COMBO_CYCLES - 1) || stable_q == 3'h0)
      begin
        collect_d = 1'b0;
        unique case (seen_d) // R23
          3'b111: cmd_d.reset = 1'b1;
          3'b011: cmd_d.confirm = 1'b1;
          3'b100: cmd_d.menu = 1'b1;
          3'b010: cmd_d.up = 1'b1;
          3'b001: cmd_d.down = 1'b1;
          default: cmd_d = '0;
        endcase
      end
      else
        win_d = win_q + 22'h000001;
    end
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      held_q <= '0;
      seen_q <= '0;
      win_q <= '0;
      collect_q <= 1'b0;
      cmd_q <= '0;
    end
    else
    begin
      held_q <= held_d;
      seen_q <= seen_d;
      win_q <= win_d;
      collect_q <= collect_d;
      cmd_q <= cmd_d;
    end
  end

  assign cmd_o = cmd_q;

endmodule

// [hdl/local_key_menu_control.sv]
// Local key interpreter, menu sequencer and LED flash codes
// Operation
// R1: Menu key toggles menu mode
// R2: Up increments, down decrements one step
// R3: Up plus down together is confirm
// R4: All three keys restart with initialization
// R5: LEDs: on, off, short, long, equal blink
// R6: Write protect ignores keys, shows message one
// R7: Initialization keeps stored configuration unchanged
// R8: Three second init, then operation or language
// R9: Language, then orientation, then menu one
// R10: First-time choices by up/down, confirm accepts
// R11: Menu: red equal blink, menus 1-4 one green
// R12: Menus 5-10 shown by green pairs
// R13: Autostart done enters operation; menu reopens
// R14: LED versions: all LEDs off in operation
// R15: Operation up/down steps readouts, skip absent
// R16: Double confirm manual; double menu exits
// R17: Diagnostics shown by display or blink code
// R18: Message class blocks operation until cleared
// R19: Error class leaves device out of operation
// R20: Limits menu local only on allowed variants
// R21: Idle minutes in menu returns to operation
// R22: Confirm clears red LED, greens show parameter
// R23: Debounce keys; near-simultaneous presses form combos
// R24: Blink period and ratios fixed by parameters
module local_key_menu_control #(
  parameter longint unsigned INIT_CYCLES = key_menu_pkg::INIT_CYC,
  parameter longint unsigned IDLE_CYCLES = key_menu_pkg::IDLE_CYC,
  parameter longint unsigned BLINK_CYCLES = key_menu_pkg::BLINK_CYC,
  parameter int unsigned DEBOUNCE_CYCLES = key_menu_pkg::DEBOUNCE_CYC,
  parameter int unsigned COMBO_CYCLES = key_menu_pkg::COMBO_CYC
)
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire key_menu_pkg::keys_t keys_i,
  input wire key_menu_pkg::status_in_t status_i,
  input wire logic [13:0] readout_present_i,
  output logic led_red_o,
  output logic [3:0] led_green_o,
  output logic [3:0] menu_num_o,
  output logic [3:0] param_num_o,
  output logic [3:0] readout_num_o,
  output logic [1:0] language_o,
  output logic orient_flipped_o,
  output logic [3:0] diag_num_o,
  output logic in_operation_o,
  output logic manual_mode_o,
  output logic restart_o,
  output logic param_store_o,
  output logic lang_store_o,
  output logic orient_store_o,
  output logic pos_up_o,
  output logic pos_down_o
);

  typedef enum logic [2:0] {
    ST_INIT,
    ST_LANG,
    ST_ORIENT,
    ST_MENU,
    ST_PARAM,
    ST_OPER,
    ST_MANUAL,
    ST_FAULT
  } state_t;

  key_menu_pkg::key_cmd_t cmd;
  state_t state_q, state_d;
  logic [3:0] menu_q, menu_d;
  logic [3:0] param_q, param_d;
  logic [3:0] read_q, read_d;
  logic [1:0] lang_q, lang_d;
  logic orient_q, orient_d;
  logic [31:0] tmr_q, tmr_d;
  logic [37:0] idle_q, idle_d;
  logic conf_once_q, conf_once_d;
  logic menu_once_q, menu_once_d;
  logic restart_q, restart_d;
  logic pstore_q, pstore_d, lstore_q, lstore_d, ostore_q, ostore_d;
  logic pup_q, pup_d, pdn_q, pdn_d;
  logic [31:0] blink_q, blink_d;
  logic [3:0] nxt_read, prv_read;
  logic [3:0] menu_up, menu_dn;
  logic keys_ok;

  key_decoder #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES), .COMBO_CYCLES(COMBO_CYCLES)) u_keys (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .keys_i(keys_i),
    .cmd_o(cmd)
  );

  assign keys_ok = !status_i.write_protect; // R6

  // Menu stepping with the limits menu skipped where not allowed
  always_comb
  begin
    menu_up = (menu_q == key_menu_pkg::MENU_LAST) ? menu_q : menu_q + 4'h1; // R2
    menu_dn = (menu_q == key_menu_pkg::MENU_FIRST) ? menu_q : menu_q - 4'h1; // R2
    if (!status_i.has_lcd && !status_i.limits_local_ok)
    begin
      if (menu_up == key_menu_pkg::MENU_LIMITS)
        menu_up = menu_up + 4'h1; // R20
      if (menu_dn == key_menu_pkg::MENU_LIMITS)
        menu_dn = menu_dn - 4'h1; // R20
    end
  end

  // Next present readout in each direction
  always_comb
  begin
    nxt_read = read_q;
    prv_read = read_q;
    for (int i = 13; i >= 1; i--)
    begin
      if (int'(read_q) + i <= int'(key_menu_pkg::READOUT_LAST)
          && readout_present_i[4'(int'(read_q) + i)])
        nxt_read = 4'(int'(read_q) + i); // R15
      if (int'(read_q) - i >= 0 && readout_present_i[4'(int'(read_q) - i)])
        prv_read = 4'(int'(read_q) - i); // R15
    end
  end

  always_comb
  begin
    state_d = state_q;
    menu_d = menu_q;
    param_d = param_q;
    read_d = read_q;
    lang_d = lang_q;
    orient_d = orient_q;
    tmr_d = tmr_q;
    idle_d = idle_q;
    conf_once_d = conf_once_q;
    menu_once_d = menu_once_q;
    restart_d = 1'b0;
    pstore_d = 1'b0;
    lstore_d = 1'b0;
    ostore_d = 1'b0;
    pup_d = 1'b0;
    pdn_d = 1'b0;
    if (cmd.reset && keys_ok)
    begin
      state_d = ST_INIT; // R4
      tmr_d = '0;
      restart_d = 1'b1;
    end
    else if (status_i.diag_error && state_q != ST_INIT)
      state_d = ST_FAULT; // R19
    else
    begin
      unique case (state_q)
        ST_INIT:
        begin
          // Stored configuration is not touched here
          if (tmr_q == 32'(INIT_CYCLES - 1)) // R7
          begin
            tmr_d = '0;
            menu_d = key_menu_pkg::MENU_FIRST;
            state_d = status_i.autostart_done ? ST_OPER : ST_LANG; // R8
          end
          else
            tmr_d = tmr_q + 32'h1;
        end
        ST_LANG:
        begin
          if (keys_ok && cmd.up && lang_q != key_menu_pkg::LANG_LAST)
            lang_d = lang_q + 2'h1; // R10
          else if (keys_ok && cmd.down && lang_q != 2'h0)
            lang_d = lang_q - 2'h1; // R10
          else if (keys_ok && cmd.confirm)
          begin
            lstore_d = 1'b1; // R10
            state_d = ST_ORIENT; // R9
          end
        end
        ST_ORIENT:
        begin
          if (keys_ok && (cmd.up || cmd.down))
            orient_d = !orient_q; // R10
          else if (keys_ok && cmd.confirm)
          begin
            ostore_d = 1'b1;
            menu_d = key_menu_pkg::MENU_FIRST; // R9
            idle_d = '0;
            state_d = ST_MENU;
          end
        end
        ST_MENU, ST_PARAM:
        begin
          if (keys_ok && (cmd.up || cmd.down || cmd.confirm || cmd.menu))
            idle_d = '0;
          else if (idle_q == 38'(IDLE_CYCLES - 1))
          begin
            if (status_i.autostart_done)
              state_d = ST_OPER; // R21
          end
          else
            idle_d = idle_q + 38'h1;
          if (keys_ok && cmd.menu)
            state_d = status_i.autostart_done ? ST_OPER : ST_MENU; // R1
          else if (keys_ok && state_q == ST_MENU)
          begin
            if (cmd.up)
              menu_d = menu_up; // R2
            else if (cmd.down)
              menu_d = menu_dn; // R2
            else if (cmd.confirm)
            begin
              param_d = 4'h1;
              state_d = ST_PARAM; // R3
            end
          end
          else if (keys_ok)
          begin
            if (cmd.up)
              param_d = param_q + 4'h1; // R2
            else if (cmd.down && param_q != 4'h1)
              param_d = param_q - 4'h1; // R2
            else if (cmd.confirm)
            begin
              pstore_d = 1'b1; // R3
              state_d = ST_MENU;
            end
          end
        end
        ST_OPER:
        begin
          if (status_i.diag_message)
            conf_once_d = 1'b0; // R18
          else if (keys_ok && cmd.menu)
          begin
            conf_once_d = 1'b0;
            menu_d = key_menu_pkg::MENU_FIRST;
            idle_d = '0;
            state_d = ST_MENU; // R13
          end
          else if (keys_ok && cmd.up)
          begin
            read_d = nxt_read; // R15
            conf_once_d = 1'b0;
          end
          else if (keys_ok && cmd.down)
          begin
            read_d = prv_read; // R15
            conf_once_d = 1'b0;
          end
          else if (keys_ok && cmd.confirm)
          begin
            conf_once_d = !conf_once_q;
            if (conf_once_q)
            begin
              menu_once_d = 1'b0;
              state_d = ST_MANUAL; // R16
            end
          end
        end
        ST_MANUAL:
        begin
          if (status_i.diag_message)
            state_d = ST_OPER; // R18
          else if (keys_ok && cmd.menu)
          begin
            menu_once_d = !menu_once_q;
            if (menu_once_q)
              state_d = ST_OPER; // R16
          end
          else if (keys_ok && (cmd.up || cmd.down))
          begin
            menu_once_d = 1'b0;
            pup_d = cmd.up; // R16
            pdn_d = cmd.down;
          end
        end
        ST_FAULT:
          state_d = ST_FAULT; // R19
        default:
          state_d = ST_INIT;
      endcase
    end
    if (state_d != ST_OPER)
      conf_once_d = (state_d == state_q) ? conf_once_d : 1'b0;
  end

  // Free-running blink phase
  always_comb
  begin
    blink_d = (blink_q == 32'(BLINK_CYCLES - 1)) ? 32'h0 : blink_q + 32'h1; // R24
  end

  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= ST_INIT;
      menu_q <= key_menu_pkg::MENU_FIRST;
      param_q <= 4'h1;
      read_q <= 4'h0;
      lang_q <= 2'h0;
      orient_q <= 1'b0;
      tmr_q <= '0;
      idle_q <= '0;
      conf_once_q <= 1'b0;
      menu_once_q <= 1'b0;
      restart_q <= 1'b0;
      pstore_q <= 1'b0;
      lstore_q <= 1'b0;
      ostore_q <= 1'b0;
      pup_q <= 1'b0;
      pdn_q <= 1'b0;
      blink_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      menu_q <= menu_d;
      param_q <= param_d;
      read_q <= read_d;
      lang_q <= lang_d;
      orient_q <= orient_d;
      tmr_q <= tmr_d;
      idle_q <= idle_d;
      conf_once_q <= conf_once_d;
      menu_once_q <= menu_once_d;
      restart_q <= restart_d;
      pstore_q <= pstore_d;
      lstore_q <= lstore_d;
      ostore_q <= ostore_d;
      pup_q <= pup_d;
      pdn_q <= pdn_d;
      blink_q <= blink_d;
    end
  end

  // LED pattern selection
  function automatic logic pattern(input key_menu_pkg::led_mode_t m, input logic [31:0] ph,
                                   input logic [31:0] per);
    logic [33:0] lim;
    lim = 34'(per) * 34'(key_menu_pkg::HALF_QUARTERS);
    unique case (m)
      key_menu_pkg::LED_OFF: pattern = 1'b0;
      key_menu_pkg::LED_ON: pattern = 1'b1;
      key_menu_pkg::LED_SHORT:
        lim = 34'(per) * 34'(key_menu_pkg::SHORT_QUARTERS);
      key_menu_pkg::LED_LONG:
        lim = 34'(per) * 34'(key_menu_pkg::LONG_QUARTERS);
      default: lim = lim;
    endcase
    if (m != key_menu_pkg::LED_OFF && m != key_menu_pkg::LED_ON)
      pattern = ({ph, 2'b00} < lim); // R5
    return pattern;
  endfunction

  key_menu_pkg::led_mode_t red_mode;
  key_menu_pkg::led_mode_t grn_mode;
  logic [3:0] grn_sel;
  logic [3:0] shown;

  always_comb
  begin
    red_mode = key_menu_pkg::LED_OFF;
    grn_mode = key_menu_pkg::LED_EQUAL;
    grn_sel = 4'h0;
    shown = (state_q == ST_PARAM) ? param_q : menu_q;
    unique case (shown) // R12
      4'h1: grn_sel = 4'b0001; // R11
      4'h2: grn_sel = 4'b0010;
      4'h3: grn_sel = 4'b0100;
      4'h4: grn_sel = 4'b1000;
      4'h5: grn_sel = 4'b0011;
      4'h6: grn_sel = 4'b0101;
      4'h7: grn_sel = 4'b1001;
      4'h8: grn_sel = 4'b0110;
      4'h9: grn_sel = 4'b1010;
      4'hA: grn_sel = 4'b1100;
      default: grn_sel = 4'b0000;
    endcase
    if (state_q == ST_MENU)
      red_mode = key_menu_pkg::LED_EQUAL; // R11
    else if (state_q == ST_PARAM)
      red_mode = key_menu_pkg::LED_OFF; // R22
    else if (state_q == ST_FAULT)
    begin
      red_mode = key_menu_pkg::LED_ON; // R17
      grn_sel = 4'h0;
    end
    else if (status_i.diag_message || status_i.write_protect)
    begin
      red_mode = key_menu_pkg::LED_SHORT; // R17
      grn_sel = 4'h0;
    end
    else
      grn_sel = 4'h0; // R14
  end

  assign led_red_o = pattern(red_mode, blink_q, BLINK_CYCLES[31:0]);
  assign led_green_o = grn_sel & {4{pattern(grn_mode, blink_q, BLINK_CYCLES[31:0])}};
  assign menu_num_o = menu_q;
  assign param_num_o = param_q;
  assign readout_num_o = read_q;
  assign language_o = lang_q;
  assign orient_flipped_o = orient_q;
  assign diag_num_o = status_i.write_protect ? key_menu_pkg::DIAG_WRITE_PROT : 4'h0; // R6
  assign in_operation_o = (state_q == ST_OPER || state_q == ST_MANUAL) && !status_i.diag_message; // R18
  assign manual_mode_o = (state_q == ST_MANUAL);
  assign restart_o = restart_q;
  assign param_store_o = pstore_q;
  assign lang_store_o = lstore_q;
  assign orient_store_o = ostore_q;
  assign pos_up_o = pup_q;
  assign pos_down_o = pdn_q;

endmodule

// [sim/key_menu_props.sv]
// Concurrent checks on the key and menu control ports
module key_menu_props #(
  parameter longint unsigned INIT_CYCLES = 100
)
(
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire key_menu_pkg::status_in_t status_i,
  input wire logic [13:0] readout_present_i,
  input wire logic led_red_o,
  input wire logic [3:0] led_green_o,
  input wire logic [3:0] menu_num_o,
  input wire logic [3:0] readout_num_o,
  input wire logic [3:0] diag_num_o,
  input wire logic in_operation_o,
  input wire logic manual_mode_o,
  input wire logic restart_o
);
  longint unsigned cnt_q;
  logic seen_q;
  // Cycles since reset release, and whether operation was reached since
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      cnt_q <= 0;
      seen_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_q + 1;
      seen_q <= seen_q | in_operation_o;
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  op_leds_off_a: assert property (in_operation_o && !manual_mode_o && !status_i.has_lcd
    && !status_i.write_protect && !status_i.diag_message && !status_i.diag_error
    |-> !led_red_o && led_green_o == 4'h0) else $error("leds lit in operation");
  wp_diag_a: assert property (diag_num_o == (status_i.write_protect ?
    key_menu_pkg::DIAG_WRITE_PROT : 4'h0)) else $error("wrong diagnostic number");
  wp_ignore_a: assert property (status_i.write_protect [*3] |-> !restart_o)
    else $error("restart while write protected");
  menu_range_a: assert property (menu_num_o >= key_menu_pkg::MENU_FIRST
    && menu_num_o <= key_menu_pkg::MENU_LAST) else $error("menu number out of range");
  restart_init_a: assert property (restart_o |=> !in_operation_o [*8])
    else $error("operation right after restart");
  init_time_a: assert property (in_operation_o && !seen_q |-> cnt_q >= INIT_CYCLES - 1)
    else $error("initialization too short");
  green_pair_a: assert property ($countones(led_green_o) <= 2)
    else $error("more than two green leds");
  readout_skip_a: assert property ($changed(readout_num_o) |-> readout_present_i[readout_num_o]
    && readout_num_o <= key_menu_pkg::READOUT_LAST) else $error("absent readout shown");
  error_out_a: assert property (status_i.diag_error [*3] |-> !in_operation_o)
    else $error("operation with error fault");

  restart_c: cover property (restart_o);
  op_entry_c: cover property ($rose(in_operation_o));
  menu_two_c: cover property (led_red_o && led_green_o[1]);
endmodule

bind local_key_menu_control key_menu_props #(.INIT_CYCLES(INIT_CYCLES)) props_i (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .status_i(status_i),
  .readout_present_i(readout_present_i), .led_red_o(led_red_o), .led_green_o(led_green_o),
  .menu_num_o(menu_num_o), .readout_num_o(readout_num_o), .diag_num_o(diag_num_o),
  .in_operation_o(in_operation_o), .manual_mode_o(manual_mode_o), .restart_o(restart_o));

// [sim/key_operator.sv]
// Operator model pressing the three local keys
module key_operator #(
  parameter int unsigned HOLD = key_menu_pkg::DEBOUNCE_CYC + 50
)
(
  input wire logic clock_i,
  output key_menu_pkg::keys_t keys_o
);
  initial keys_o = 3'h0;

  // Hold past the debounce time, then release fully before the next group
  task automatic press(input key_menu_pkg::keys_t k);
  begin
    @(negedge clock_i);
    keys_o = k;
    repeat (HOLD) @(negedge clock_i);
    keys_o = 3'h0;
    repeat (HOLD) @(negedge clock_i);
  end
  endtask
endmodule

// [sim/local_key_menu_control_tb.sv]
// Self-checking bench for the local key and menu control block
module local_key_menu_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam longint unsigned INIT_N = 100;
  localparam int unsigned BLINK_N = 16;
  localparam longint unsigned IDLE_N = 200;
  localparam int unsigned DEB_N = 8;
  localparam int unsigned COMBO_N = 64;
  localparam int unsigned LIMIT = 6_000;
  logic clock_i;
  logic sys_rst_i;
  key_menu_pkg::keys_t keys;
  key_menu_pkg::status_in_t status;
  logic [13:0] present;
  logic led_red, orient, in_op, manual, restart, pstore, lstore, ostore, pup, pdown;
  logic [3:0] led_green, menu_num, param_num, readout_num, diag_num;
  logic [1:0] language;
  logic [3:0] menu_prev;
  logic [3:0] exp_menu[$];
  logic [31:0] rnd;
  int err_total;
  int total_checks;
  int restarts;
  int lang_stores;
  int pstores, ostores, pups, pdowns;
  int cycles;

  initial
  begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  local_key_menu_control #(.INIT_CYCLES(INIT_N), .IDLE_CYCLES(IDLE_N), .BLINK_CYCLES(BLINK_N),
    .DEBOUNCE_CYCLES(DEB_N), .COMBO_CYCLES(COMBO_N)) uut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .keys_i(keys), .status_i(status),
    .readout_present_i(present), .led_red_o(led_red), .led_green_o(led_green),
    .menu_num_o(menu_num), .param_num_o(param_num), .readout_num_o(readout_num),
    .language_o(language), .orient_flipped_o(orient), .diag_num_o(diag_num),
    .in_operation_o(in_op), .manual_mode_o(manual), .restart_o(restart),
    .param_store_o(pstore), .lang_store_o(lstore), .orient_store_o(ostore),
    .pos_up_o(pup), .pos_down_o(pdown));

  key_operator #(.HOLD(DEB_N + 20)) op (.clock_i(clock_i), .keys_o(keys));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Over one blink period an equal flash is lit exactly half the time
  task automatic blink_check(input logic [3:0] green);
    int reds;
    int greens;
    reds = 0;
    greens = 0;
    repeat (BLINK_N)
    begin
      @(negedge clock_i);
      if (led_red === 1'b1)
        reds++;
      if (led_green === green)
        greens++;
      else if (led_green !== 4'h0)
        greens = 99;
    end
    check("red on time", reds, BLINK_N / 2);
    check("green on time", greens, BLINK_N / 2);
  endtask

  function automatic logic [3:0] next_readout(input logic [13:0] m);
    for (int i = 1; i < 14; i++)
      if (m[i])
        return i[3:0];
    return 4'h0;
  endfunction

  // Result watcher: menu steps against the noted queue, pulses counted
  always @(negedge clock_i)
  begin
    cycles++;
    if (restart === 1'b1)
      restarts++;
    if (lstore === 1'b1)
      lang_stores++;
    pstores += int'(pstore === 1'b1);
    ostores += int'(ostore === 1'b1);
    pups += int'(pup === 1'b1);
    pdowns += int'(pdown === 1'b1);
    if (!sys_rst_i && menu_num !== menu_prev)
      check("menu_num", menu_num, exp_menu.size() ? exp_menu.pop_front() : menu_prev);
    menu_prev = menu_num;
    if (cycles == LIMIT)
    begin
      err_total++;
      give_verdict();
    end
  end

  task automatic reset_and_init;
    sys_rst_i = 1'b1;
    repeat (16) @(negedge clock_i);
    sys_rst_i = 1'b0;
    repeat (INIT_N + 20) @(negedge clock_i);
  endtask

  initial
  begin
    sys_rst_i = 1'b1;
    status = 6'h08;
    rnd = lfsr(32'h6D9972C0);
    present = rnd[13:0] | 14'h0009;
    reset_and_init();
    check("in_operation", in_op, 1);
    check("leds", {led_red, led_green}, 0);
    op.press(3'h4);
    check("in_operation", in_op, 0);
    blink_check(4'h1);
    exp_menu.push_back(4'h2);
    op.press(3'h2);
    blink_check(4'h2);
    exp_menu.push_back(4'h3);
    exp_menu.push_back(4'h4);
    exp_menu.push_back(4'h6);
    repeat (3) op.press(3'h2);
    check("menu_num", menu_num, 4'h6);
    blink_check(4'h5);
    status.limits_local_ok = 1'b1;
    exp_menu.push_back(4'h5);
    op.press(3'h1);
    blink_check(4'h3);
    op.press(3'h3);
    check("red in parameter", led_red, 0);
    op.press(3'h2);
    check("param_num", param_num, 2);
    op.press(3'h3);
    check("param stores", pstores, 1);
    status.write_protect = 1'b1;
    op.press(3'h2);
    check("diag_num", diag_num, key_menu_pkg::DIAG_WRITE_PROT);
    check("menu_num", menu_num, 4'h5);
    status.write_protect = 1'b0;
    op.press(3'h4);
    check("in_operation", in_op, 1);
    exp_menu.push_back(4'h1);
    op.press(3'h4);
    check("in_operation", in_op, 0);
    repeat (IDLE_N + 20) @(negedge clock_i);
    check("in_operation", in_op, 1);
    op.press(3'h2);
    check("readout_num", readout_num, next_readout(present));
    op.press(3'h1);
    check("readout_num", readout_num, 0);
    status.diag_message = 1'b1;
    op.press(3'h2);
    check("in_operation", in_op, 0);
    check("readout_num", readout_num, 0);
    status.diag_message = 1'b0;
    repeat (2) op.press(3'h3);
    check("manual", manual, 1);
    op.press(3'h2);
    op.press(3'h1);
    check("position ups", pups, 1);
    check("position downs", pdowns, 1);
    repeat (2) op.press(3'h4);
    check("manual", manual, 0);
    op.press(3'h7);
    check("restarts", restarts, 1);
    check("in_operation", in_op, 0);
    repeat (INIT_N) @(negedge clock_i);
    check("in_operation", in_op, 1);
    status.autostart_done = 1'b0;
    status.has_lcd = 1'b1;
    rnd = lfsr(rnd);
    present = rnd[13:0] | 14'h0001;
    reset_and_init();
    check("in_operation", in_op, 0);
    check("language", language, 0);
    op.press(3'h2);
    check("language", language, 1);
    op.press(3'h3);
    check("lang_stores", lang_stores, 1);
    op.press(3'h2);
    op.press(3'h3);
    check("orient", orient, 1);
    check("orient stores", ostores, 1);
    blink_check(4'h1);
    status.diag_error = 1'b1;
    repeat (4) @(negedge clock_i);
    check("red in fault", led_red, 1);
    op.press(3'h4);
    check("in_operation", in_op, 0);
    check("pending menu steps", exp_menu.size(), 0);
    give_verdict();
  end
endmodule
